// ---- rtl/pwm_channel.sv ----
// Purpose: One waveform channel with deferred period and duty update.
// Assumes: Single-cycle register strobes on clk_sys_i, 40 MHz.
// Notes: Update timing and status quirks are reproduced on purpose.
//
// Contract
// - Counter at 0 or 1: update applies immediately.
// - Zero period blocks the deferred period update.
// - Left-aligned: first period from 0, later 1.
// - Early disable stops output, flag stays set.
`default_nettype none
module pwm_channel #(
	parameter int CNT_W = pwm_pkg::CNT_W_DEF
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire pwm_pkg::bus_req_s bus_i,
	output logic [31:0] rdata_o,
	output logic pwm_o
);

	if (CNT_W < 2 || CNT_W > 16) begin : g_chk
		$error("CNT_W must lie between 2 and 16");
	end

	localparam logic [CNT_W-1:0] CNT_ZERO = '0;
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	// Register decode.
	wire wr_ena = bus_i.wr && (bus_i.addr == pwm_pkg::OFS_ENA);
	wire wr_dis = bus_i.wr && (bus_i.addr == pwm_pkg::OFS_DIS);
	wire wr_mode = bus_i.wr && (bus_i.addr == pwm_pkg::OFS_MODE);
	wire wr_per = bus_i.wr && (bus_i.addr == pwm_pkg::OFS_PERIOD);
	wire wr_duty = bus_i.wr && (bus_i.addr == pwm_pkg::OFS_DUTY);
	wire wr_upd = bus_i.wr && (bus_i.addr == pwm_pkg::OFS_UPDATE);

	wire ena_cmd = wr_ena && bus_i.wdata[pwm_pkg::ENA_BIT];
	wire channel_disable_cmd = wr_dis && bus_i.wdata[pwm_pkg::ENA_BIT];
	wire [CNT_W-1:0] wval = bus_i.wdata[CNT_W-1:0];

	logic [pwm_pkg::MODE_W-1:0] mode_r;
	logic [CNT_W-1:0] channel_period_value;
	logic [CNT_W-1:0] channel_duty_value;
	logic [CNT_W-1:0] channel_counter_value;
	logic [CNT_W-1:0] upd_val_r;
	logic upd_per_r;
	logic upd_pend_r;
	logic channel_enabled_flag;
	logic tick_seen_r;
	pwm_pkg::cnt_state_e state_r;
	logic [15:0] presc_r;
	logic pwm_r;
	logic [31:0] rdata_r;

	logic [pwm_pkg::MODE_W-1:0] mode_nxt;
	logic [CNT_W-1:0] period_nxt;
	logic [CNT_W-1:0] duty_nxt;
	logic [CNT_W-1:0] cnt_nxt;
	logic [CNT_W-1:0] upd_val_nxt;
	logic upd_per_nxt;
	logic upd_pend_nxt;
	logic flag_nxt;
	logic tick_seen_nxt;
	pwm_pkg::cnt_state_e state_nxt;
	logic pwm_nxt;
	logic [31:0] rdata_nxt;

	// Mode fields.
	wire center = mode_r[pwm_pkg::CENTER_BIT];
	wire polarity = mode_r[pwm_pkg::POL_BIT];
	wire upd_target_per = mode_r[pwm_pkg::UPD_PER_BIT];
	wire [pwm_pkg::PRE_W-1:0] pre_sel = mode_r[pwm_pkg::PRE_LSB +: pwm_pkg::PRE_W];

	// Selected channel clock is a one-cycle tick every 2^pre_sel cycles.
	// A shared free-running divider keeps the phase of the tick unknown to
	// software, which is why an early disable can land before the first one.
	wire [15:0] pre_mask = 16'((16'h0001 << pre_sel) - 16'h0001);
	wire tick = (presc_r & pre_mask) == pre_mask;

	wire running = state_r != pwm_pkg::ST_IDLE;
	wire at_top = channel_counter_value >= channel_period_value;
	wire at_low = channel_counter_value <= CNT_ONE;

	// End of a period: left-aligned at the top, centre-aligned at the bottom.
	wire left_wrap = (state_r == pwm_pkg::ST_UP) && !center && tick && at_top;
	wire center_wrap = (state_r == pwm_pkg::ST_DOWN) && tick &&
		(channel_counter_value == CNT_ZERO);
	wire boundary = left_wrap || center_wrap;

	// A pending period value is held back while the period is zero.
	wire apply_ok = !(upd_per_r && (channel_period_value == CNT_ZERO));
	wire apply_pend = boundary && upd_pend_r && apply_ok;
	wire upd_now = wr_upd && at_low;

	wire [31:0] status_word = (32'(channel_enabled_flag) << pwm_pkg::FLAG_BIT) |
		(32'(running) << pwm_pkg::RUN_BIT) | (32'(upd_pend_r) << pwm_pkg::PEND_BIT);

	// Counter and state sequencing.
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = channel_counter_value;
		tick_seen_nxt = tick_seen_r;
		flag_nxt = channel_enabled_flag;
		if (running && tick) begin
			tick_seen_nxt = 1'b1;
		end
		case (state_r)
			pwm_pkg::ST_IDLE: begin
				cnt_nxt = CNT_ZERO;
			end
			pwm_pkg::ST_UP: begin
				if (tick) begin
					if (!at_top) begin
						cnt_nxt = channel_counter_value + CNT_ONE;
					end else if (center) begin
						state_nxt = pwm_pkg::ST_DOWN;
						cnt_nxt = channel_counter_value - CNT_ONE;
					end else begin
						cnt_nxt = CNT_ONE;
					end
				end
			end
			pwm_pkg::ST_DOWN: begin
				if (tick) begin
					if (channel_counter_value == CNT_ZERO) begin
						state_nxt = pwm_pkg::ST_UP;
						cnt_nxt = CNT_ONE;
					end else begin
						cnt_nxt = channel_counter_value - CNT_ONE;
					end
				end
			end
			default: begin
				state_nxt = pwm_pkg::ST_IDLE;
				cnt_nxt = CNT_ZERO;
			end
		endcase
		if (ena_cmd) begin
			state_nxt = pwm_pkg::ST_UP;
			cnt_nxt = CNT_ZERO;
			tick_seen_nxt = 1'b0;
			flag_nxt = 1'b1;
		end else if (channel_disable_cmd) begin
			state_nxt = pwm_pkg::ST_IDLE;
			cnt_nxt = CNT_ZERO;
			// Before the first selected clock the flag is left standing.
			if (tick_seen_r) begin
				flag_nxt = 1'b0;
			end
		end
	end

	// Period, duty and the update holding register.
	always_comb begin
		period_nxt = channel_period_value;
		duty_nxt = channel_duty_value;
		upd_val_nxt = upd_val_r;
		upd_per_nxt = upd_per_r;
		upd_pend_nxt = upd_pend_r;
		mode_nxt = mode_r;
		if (apply_pend) begin
			if (upd_per_r) begin
				period_nxt = upd_val_r;
			end else begin
				duty_nxt = upd_val_r;
			end
			upd_pend_nxt = 1'b0;
		end
		// A deferred update write in the apply cycle wins over the clear; an immediate one leaves the pending flag cleared.
		if (wr_upd) begin
			if (upd_now) begin
				if (upd_target_per) begin
					period_nxt = wval;
				end else begin
					duty_nxt = wval;
				end
			end else begin
				upd_val_nxt = wval;
				upd_per_nxt = upd_target_per;
				upd_pend_nxt = 1'b1;
			end
		end
		if (wr_per) begin
			period_nxt = wval;
		end
		if (wr_duty) begin
			duty_nxt = wval;
		end
		if (wr_mode) begin
			mode_nxt = bus_i.wdata[pwm_pkg::MODE_W-1:0];
		end
	end

	// Output level; a stopped channel drives low whatever the flag says.
	assign pwm_nxt = running &&
		((channel_counter_value < channel_duty_value) ^ polarity);

	// Read data, registered; unmapped offsets read as zero.
	always_comb begin
		rdata_nxt = 32'h0;
		if (bus_i.rd) begin
			case (bus_i.addr)
				pwm_pkg::OFS_STATUS: rdata_nxt = status_word;
				pwm_pkg::OFS_MODE: rdata_nxt = 32'(mode_r);
				pwm_pkg::OFS_PERIOD: rdata_nxt = 32'(channel_period_value);
				pwm_pkg::OFS_DUTY: rdata_nxt = 32'(channel_duty_value);
				pwm_pkg::OFS_UPDATE: rdata_nxt = 32'(upd_val_r);
				pwm_pkg::OFS_COUNTER: rdata_nxt = 32'(channel_counter_value);
				default: rdata_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			mode_r <= pwm_pkg::MODE_RST;
			channel_period_value <= CNT_W'(pwm_pkg::PERIOD_RST);
			channel_duty_value <= CNT_W'(pwm_pkg::DUTY_RST);
			channel_counter_value <= CNT_ZERO;
			upd_val_r <= CNT_ZERO;
			upd_per_r <= 1'b0;
			upd_pend_r <= 1'b0;
			channel_enabled_flag <= 1'b0;
			tick_seen_r <= 1'b0;
			state_r <= pwm_pkg::ST_IDLE;
			presc_r <= 16'h0;
			pwm_r <= 1'b0;
			rdata_r <= 32'h0;
		end else begin
			mode_r <= mode_nxt;
			channel_period_value <= period_nxt;
			channel_duty_value <= duty_nxt;
			channel_counter_value <= cnt_nxt;
			upd_val_r <= upd_val_nxt;
			upd_per_r <= upd_per_nxt;
			upd_pend_r <= upd_pend_nxt;
			channel_enabled_flag <= flag_nxt;
			tick_seen_r <= tick_seen_nxt;
			state_r <= state_nxt;
			presc_r <= presc_r + 16'h0001;
			pwm_r <= pwm_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata_o = rdata_r;
	assign pwm_o = pwm_r;

	// Checks.
	sequence s_disable_held;
		(state_r == pwm_pkg::ST_IDLE) && channel_enabled_flag;
	endsequence

	sequence s_output_low;
		!pwm_r;
	endsequence

	property p_upd_imm;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(wr_upd && at_low && upd_target_per)
		|=> (channel_period_value == $past(wval));
	endproperty
	a_upd_imm: assert property (p_upd_imm)
		else $error("Update at counter 0 or 1 not applied at once");

	property p_upd_defer;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(wr_upd && !at_low && !upd_pend_r)
		|=> upd_pend_r && $stable(channel_period_value) && $stable(channel_duty_value);
	endproperty
	a_upd_defer: assert property (p_upd_defer)
		else $error("Update applied before the period end");

	property p_zero_period_hold;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(boundary && upd_pend_r && upd_per_r && (channel_period_value == CNT_ZERO) &&
			!bus_i.wr)
		|=> upd_pend_r && (channel_period_value == CNT_ZERO);
	endproperty
	a_zero_period_hold: assert property (p_zero_period_hold)
		else $error("Period update took effect with zero period");

	property p_start_value;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(ena_cmd |=> channel_counter_value == CNT_ZERO) and
		((left_wrap && !bus_i.wr) |=> channel_counter_value == CNT_ONE);
	endproperty
	a_start_value: assert property (p_start_value)
		else $error("Left-aligned counter start value wrong");

	property p_early_disable;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(channel_disable_cmd && !tick_seen_r && channel_enabled_flag)
		|=> s_disable_held ##1 s_output_low;
	endproperty
	a_early_disable: assert property (p_early_disable)
		else $error("Early disable did not keep flag or stop output");

	property p_late_disable;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(channel_disable_cmd && tick_seen_r)
		|=> !channel_enabled_flag ##1 s_output_low;
	endproperty
	a_late_disable: assert property (p_late_disable)
		else $error("Normal disable left the enabled flag set");

endmodule
`default_nettype wire

// ---- rtl/pwm_pkg.sv ----
// Purpose: Shared constants and types of the waveform channel.
// Assumes: One channel, registers one 32-bit word each.
// Notes: Reset values of period and duty are never zero.
`default_nettype none
package pwm_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W_DEF = 16;
	localparam int PRE_W = 4;

	localparam logic [7:0] OFS_ENA = 8'h00;
	localparam logic [7:0] OFS_DIS = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_MODE = 8'h0c;
	localparam logic [7:0] OFS_PERIOD = 8'h10;
	localparam logic [7:0] OFS_DUTY = 8'h14;
	localparam logic [7:0] OFS_UPDATE = 8'h18;
	localparam logic [7:0] OFS_COUNTER = 8'h1c;

	localparam int ENA_BIT = 0;
	localparam int FLAG_BIT = 0;
	localparam int RUN_BIT = 1;
	localparam int PEND_BIT = 2;
	localparam int CENTER_BIT = 0;
	localparam int POL_BIT = 1;
	localparam int UPD_PER_BIT = 2;
	localparam int PRE_LSB = 4;
	localparam int MODE_W = 8;

	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [15:0] PERIOD_RST = 16'h0010;
	localparam logic [15:0] DUTY_RST = 16'h0008;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} bus_req_s;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_UP,
		ST_DOWN
	} cnt_state_e;
endpackage
`default_nettype wire

// ---- sim/pwm_load.sv ----
// Purpose: Passive load on the waveform pin that counts rising edges.
// Assumes: The pin is sampled on the system clock.
// Notes: It never drives the pin back.
`default_nettype none
module pwm_load (
	input wire logic clk_sys_i,
	input wire logic pin_i,
	output var int edges_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic last_r = 1'b0;
	int count_r = 0;
	assign edges_o = count_r;
	always @(posedge clk_sys_i) begin
		if (pin_i && !last_r) count_r++;
		last_r <= pin_i;
	end
endmodule
`default_nettype wire

// ---- sim/test_pwm_channel.sv ----
// Purpose: Self-checking bench for one waveform channel.
// Assumes: Prescaler 0 except in the early-disable case.
// Notes: The model counts at prescaler 0 only; the last update loop runs centre-aligned.
`default_nettype none
module test_pwm_channel_update_behaviour;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	pwm_pkg::bus_req_s bus = '0;
	logic [31:0] rdata;
	logic pwm;
	int edges;
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;
	int seed = 32'h0e17;
	int cnt, per, duty, mode, upd, run, flag, seen, pend, pt, pw, rexp, down;
	pwm_channel pwm_channel_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .bus_i(bus),
		.rdata_o(rdata), .pwm_o(pwm));
	pwm_load pwm_load_inst (.clk_sys_i(clk_sys_i), .pin_i(pwm), .edges_o(edges));
	initial begin
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("compares=%0d miscompares=%0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clk_sys_i);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys_i);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk_sys_i);
		bus.rd <= 1'b0;
		#1;
		check(rdata, rexp);
	endtask
	// Reference model; values before the edge decide, as in the design.
	always @(posedge clk_sys_i) begin
		int c0, wrap;
		c0 = cnt;
		pw = run & ((cnt < duty) ^ mode[1]);
		rexp = 0;
		if (bus.rd) begin
			case (bus.addr)
				pwm_pkg::OFS_STATUS: rexp = flag << pwm_pkg::FLAG_BIT | run << pwm_pkg::RUN_BIT |
					pend << pwm_pkg::PEND_BIT;
				pwm_pkg::OFS_MODE: rexp = mode;
				pwm_pkg::OFS_PERIOD: rexp = per;
				pwm_pkg::OFS_DUTY: rexp = duty;
				pwm_pkg::OFS_UPDATE: rexp = upd;
				pwm_pkg::OFS_COUNTER: rexp = cnt;
				default: rexp = 0;
			endcase
		end
		if (!resetn_i) begin
			cnt = 0;
			down = 0;
			upd = 0;
			seen = 0;
			per = pwm_pkg::PERIOD_RST;
			duty = pwm_pkg::DUTY_RST;
			mode = 0;
			run = 0;
			flag = 0;
			pend = 0;
			pw = 0;
		end else begin
			wrap = 0;
			if (run && mode[7:4] == 0) begin
				seen = 1;
				if (down) begin
					if (cnt == 0) begin
						down = 0;
						cnt = 1;
						wrap = 1;
					end else cnt--;
				end else if (cnt < per) cnt++;
				else if (mode[0]) begin
					down = 1;
					cnt--;
				end else begin
					cnt = 1;
					wrap = 1;
				end
			end
			if (wrap && pend && !(pt && per == 0)) begin
				if (pt) per = upd;
				else duty = upd;
				pend = 0;
			end
			if (bus.wr) begin
				case (bus.addr)
					pwm_pkg::OFS_ENA: if (bus.wdata[0]) begin
						run = 1;
						flag = 1;
						cnt = 0;
						seen = 0;
						down = 0;
					end
					pwm_pkg::OFS_DIS: if (bus.wdata[0]) begin
						run = 0;
						cnt = 0;
						down = 0;
						if (seen) flag = 0;
					end
					pwm_pkg::OFS_MODE: mode = bus.wdata[7:0];
					pwm_pkg::OFS_PERIOD: per = bus.wdata[15:0];
					pwm_pkg::OFS_DUTY: duty = bus.wdata[15:0];
					pwm_pkg::OFS_UPDATE: begin
						// An immediate write leaves the held update value untouched.
						if (c0 <= 1) begin
							if (mode[2]) per = bus.wdata[15:0];
							else duty = bus.wdata[15:0];
						end else begin
							upd = bus.wdata[15:0];
							pend = 1;
							pt = mode[2];
						end
					end
					default: ;
				endcase
			end
		end
		#1;
		check(32'(pwm), pw);
		check(rdata, rexp);
		cycles++;
		if (cycles > 20000) begin
			miscompares++;
			summarize();
		end
	end
	initial begin
		int v;
		repeat (6) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		rd(pwm_pkg::OFS_PERIOD);
		rd(pwm_pkg::OFS_DUTY);
		rd(pwm_pkg::OFS_MODE);
		rd(8'h20);
		wr(pwm_pkg::OFS_COUNTER, 32'h5);
		wr(pwm_pkg::OFS_PERIOD, 32'h4);
		wr(pwm_pkg::OFS_DUTY, 32'h2);
		wr(pwm_pkg::OFS_ENA, 32'h1);
		repeat (12) rd(pwm_pkg::OFS_COUNTER);
		// Update values stay nonzero, as software must keep them.
		for (int t = 0; t < 3; t++) begin
			wr(pwm_pkg::OFS_MODE, (t == 2) ? 32'h5 : 32'(t * 6));
			for (int i = 0; i < 20; i++) begin
				v = $random(seed);
				rd(pwm_pkg::OFS_COUNTER);
				wr(pwm_pkg::OFS_UPDATE, 32'(v[7:4]) + 32'h2);
				rd(pwm_pkg::OFS_STATUS);
				repeat (v[10:8]) @(posedge clk_sys_i);
			end
			repeat (40) @(posedge clk_sys_i);
			rd(pwm_pkg::OFS_UPDATE);
		end
		wr(pwm_pkg::OFS_MODE, 32'h6);
		wr(pwm_pkg::OFS_DIS, 32'h1);
		rd(pwm_pkg::OFS_STATUS);
		wr(pwm_pkg::OFS_PERIOD, 32'h10);
		wr(pwm_pkg::OFS_ENA, 32'h1);
		repeat (4) @(posedge clk_sys_i);
		wr(pwm_pkg::OFS_UPDATE, 32'h5);
		wr(pwm_pkg::OFS_PERIOD, 32'h0);
		repeat (20) @(posedge clk_sys_i);
		rd(pwm_pkg::OFS_STATUS);
		rd(pwm_pkg::OFS_PERIOD);
		wr(pwm_pkg::OFS_PERIOD, 32'h8);
		repeat (20) @(posedge clk_sys_i);
		rd(pwm_pkg::OFS_PERIOD);
		wr(pwm_pkg::OFS_DIS, 32'h1);
		wr(pwm_pkg::OFS_MODE, 32'hf0);
		wr(pwm_pkg::OFS_ENA, 32'h1);
		wr(pwm_pkg::OFS_DIS, 32'h1);
		rd(pwm_pkg::OFS_STATUS);
		repeat (8) @(posedge clk_sys_i);
		check(32'(edges != 0), 32'h1);
		summarize();
	end
endmodule
`default_nettype wire
